// file: thermometer_command_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module thermometer_command_decoder #(
    parameter int NV_WRITE_CYC = thermo_pkg::NV_WRITE_CYC
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_link_clk,
    input wire logic [2:0] i_addr_sel,
    input wire logic i_lk_start,
    input wire logic i_lk_stop,
    input wire logic i_lk_byte_vld,
    input wire logic [7:0] i_lk_byte,
    input wire logic i_lk_rd_req,
    output logic o_lk_ack,
    output logic [7:0] o_lk_rd_byte,
    input wire logic [15:0] i_temp,
    input wire logic [7:0] i_count_remain,
    input wire logic [7:0] i_count_per_c,
    input wire logic i_conv_done,
    output logic o_conv_go,
    output logic o_conv_active,
    output logic o_cont_mode,
    output logic o_thermo_pol,
    output logic [15:0] o_high_limit,
    output logic [15:0] o_low_limit,
    output logic [7:0] o_config,
    output logic o_nv_busy
);
    // link domain
    logic [2:0] asel_s1_q, asel_s2_q;
    logic first_q, first_d, addressed_q, addressed_d, rd_mode_q, rd_mode_d, rd_idx_q, rd_idx_d;
    logic [15:0] rd_word_lk_q, rd_word_lk_d, rd_word_q, rd_word_d;
    logic [7:0] rd_byte_q, rd_byte_d;
    thermo_pkg::link_evt_t evt_q, evt_d;
    logic evt_tgl_q, evt_tgl_d, rd_tgl_q, rd_tgl_d;
    logic rtgl_s1_q, rtgl_s2_q, rtgl_s3_q, lk_hit;
    assign lk_hit = (i_lk_byte[7:4] == thermo_pkg::DEV_TYPE) && (i_lk_byte[3:1] == asel_s2_q);
    // address bytes only on a hit, then every written byte
    assign o_lk_ack = i_lk_byte_vld && (first_q ? lk_hit : (addressed_q && !rd_mode_q));
    assign o_lk_rd_byte = rd_byte_q;
    always_comb begin
        first_d = first_q;
        addressed_d = addressed_q;
        rd_mode_d = rd_mode_q;
        rd_idx_d = rd_idx_q;
        rd_word_lk_d = rd_word_lk_q;
        rd_byte_d = rd_byte_q;
        evt_d = evt_q;
        evt_tgl_d = evt_tgl_q;
        // word is frozen while a read is under way so two bytes never tear
        if ((rtgl_s2_q != rtgl_s3_q) && !(addressed_q && rd_mode_q)) begin
            rd_word_lk_d = rd_word_q;
        end
        if (i_lk_start) begin
            first_d = 1'b1;
            addressed_d = 1'b0;
            evt_d = '{kind: thermo_pkg::EVT_START, addr_byte: 1'b0, hit: 1'b0, data: 8'h00};
            evt_tgl_d = !evt_tgl_q;
        end else if (i_lk_stop) begin
            first_d = 1'b0;
            addressed_d = 1'b0;
            evt_d = '{kind: thermo_pkg::EVT_STOP, addr_byte: 1'b0, hit: 1'b0, data: 8'h00};
            evt_tgl_d = !evt_tgl_q;
        end else if (i_lk_byte_vld) begin
            first_d = 1'b0;
            if (first_q) begin
                addressed_d = lk_hit;
                rd_mode_d = i_lk_byte[0];
                rd_idx_d = 1'b0;
            end
            evt_d = '{kind: thermo_pkg::EVT_BYTE, addr_byte: first_q, hit: lk_hit,
                      data: i_lk_byte};
            evt_tgl_d = !evt_tgl_q;
        end
        if (i_lk_rd_req && addressed_q && rd_mode_q) begin
            // most significant byte first
            rd_byte_d = rd_idx_q ? rd_word_lk_q[7:0] : rd_word_lk_q[15:8];
            rd_idx_d = !rd_idx_q;
        end
    end
    always_ff @(posedge i_link_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            asel_s1_q <= 3'h0;
            asel_s2_q <= 3'h0;
            first_q <= 1'b0;
            addressed_q <= 1'b0;
            rd_mode_q <= 1'b0;
            rd_idx_q <= 1'b0;
            rd_word_lk_q <= 16'h0000;
            rd_byte_q <= 8'h00;
            evt_q <= '{kind: thermo_pkg::EVT_STOP, addr_byte: 1'b0, hit: 1'b0, data: 8'h00};
            evt_tgl_q <= 1'b0;
            rtgl_s1_q <= 1'b0;
            rtgl_s2_q <= 1'b0;
            rtgl_s3_q <= 1'b0;
        end else begin
            asel_s1_q <= i_addr_sel;
            asel_s2_q <= asel_s1_q;
            first_q <= first_d;
            addressed_q <= addressed_d;
            rd_mode_q <= rd_mode_d;
            rd_idx_q <= rd_idx_d;
            rd_word_lk_q <= rd_word_lk_d;
            rd_byte_q <= rd_byte_d;
            evt_q <= evt_d;
            evt_tgl_q <= evt_tgl_d;
            rtgl_s1_q <= rd_tgl_q;
            rtgl_s2_q <= rtgl_s1_q;
            rtgl_s3_q <= rtgl_s2_q;
        end
    end
    // core domain
    logic etgl_s1_q, etgl_s2_q, etgl_s3_q, evt_new, evt_byte, cmd_byte;
    thermo_pkg::xact_state_t st_q, st_d;
    logic [7:0] cmd_q, cmd_d, hold_q, hold_d, cfg_q, cfg_d;
    logic [15:0] high_q, high_d, low_q, low_d;
    logic [thermo_pkg::NV_CNT_W-1:0] nv_cnt_q, nv_cnt_d;
    logic cont_run_q, cont_run_d, active_q, active_d, go_q, go_d, idx_q, idx_d, commit;
    // evt_q is held stable for a full link period after its toggle moves
    assign evt_new = etgl_s2_q != etgl_s3_q;
    assign evt_byte = evt_new && (evt_q.kind == thermo_pkg::EVT_BYTE);
    always_comb begin
        st_d = st_q;
        cmd_d = cmd_q;
        hold_d = hold_q;
        cfg_d = cfg_q;
        high_d = high_q;
        low_d = low_q;
        idx_d = idx_q;
        rd_word_d = rd_word_q;
        rd_tgl_d = rd_tgl_q;
        cont_run_d = cont_run_q;
        active_d = active_q;
        go_d = 1'b0;
        commit = 1'b0;
        nv_cnt_d = (nv_cnt_q != '0) ? nv_cnt_q - 1'b1 : nv_cnt_q;
        // conversion completes even after a stop; repeat only while running
        if (i_conv_done && active_q) begin
            active_d = cont_run_q;
            go_d = cont_run_q;
        end
        if (i_conv_done && active_q && cmd_q == thermo_pkg::CMD_READ_TEMP) begin
            rd_word_d = i_temp;
            rd_tgl_d = !rd_tgl_q;
        end
        if (evt_new && evt_q.kind == thermo_pkg::EVT_START) begin
            st_d = thermo_pkg::ST_ADDR;
        end else if (evt_new && evt_q.kind == thermo_pkg::EVT_STOP) begin
            st_d = thermo_pkg::ST_IDLE;
        end else if (evt_byte) begin
            case (st_q)
                thermo_pkg::ST_ADDR: begin
                    // reads are served by the link side from the held word
                    st_d = (evt_q.hit && !evt_q.data[0]) ? thermo_pkg::ST_CMD
                                                         : thermo_pkg::ST_IDLE;
                end
                thermo_pkg::ST_CMD: begin
                    cmd_d = evt_q.data;
                    idx_d = 1'b0;
                    st_d = thermo_pkg::ST_HOLD;
                    rd_tgl_d = !rd_tgl_q;
                    case (evt_q.data)
                        thermo_pkg::CMD_STOP_CONV: cont_run_d = 1'b0;
                        thermo_pkg::CMD_START_CONV: begin
                            cont_run_d = !cfg_q[thermo_pkg::CFG_ONESHOT_BIT];
                            active_d = 1'b1;
                            go_d = !active_q || i_conv_done;
                        end
                        thermo_pkg::CMD_READ_TEMP: rd_word_d = i_temp;
                        thermo_pkg::CMD_READ_COUNT: rd_word_d = {i_count_remain, 8'h00};
                        thermo_pkg::CMD_READ_SLOPE: rd_word_d = {i_count_per_c, 8'h00};
                        thermo_pkg::UPPER_THRESHOLD_CMD: begin
                            rd_word_d = high_q;
                            st_d = thermo_pkg::ST_DATA;
                        end
                        thermo_pkg::LOWER_THRESHOLD_CMD: begin
                            rd_word_d = low_q;
                            st_d = thermo_pkg::ST_DATA;
                        end
                        thermo_pkg::CMD_CONFIG: begin
                            rd_word_d = {cfg_q, 8'h00};
                            st_d = thermo_pkg::ST_DATA;
                        end
                        default: rd_tgl_d = rd_tgl_q;
                    endcase
                end
                thermo_pkg::ST_DATA: begin
                    if (cmd_q == thermo_pkg::CMD_CONFIG) begin
                        cfg_d = evt_q.data;
                        cont_run_d = cont_run_q && !evt_q.data[thermo_pkg::CFG_ONESHOT_BIT];
                        rd_word_d = {evt_q.data, 8'h00};
                        commit = 1'b1;
                    end else if (!idx_q) begin
                        hold_d = evt_q.data;
                        idx_d = 1'b1;
                    end else begin
                        if (cmd_q == thermo_pkg::UPPER_THRESHOLD_CMD) begin
                            high_d = {hold_q, evt_q.data};
                        end else begin
                            low_d = {hold_q, evt_q.data};
                        end
                        rd_word_d = {hold_q, evt_q.data};
                        commit = 1'b1;
                    end
                    if (commit) begin
                        st_d = thermo_pkg::ST_HOLD;
                        rd_tgl_d = !rd_tgl_q;
                        nv_cnt_d = NV_WRITE_CYC[thermo_pkg::NV_CNT_W-1:0];
                    end
                end
                default: st_d = thermo_pkg::ST_IDLE;
            endcase
        end
    end
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            etgl_s1_q <= 1'b0;
            etgl_s2_q <= 1'b0;
            etgl_s3_q <= 1'b0;
            st_q <= thermo_pkg::ST_IDLE;
            cmd_q <= 8'h00;
            hold_q <= 8'h00;
            cfg_q <= thermo_pkg::CFG_RESET;
            high_q <= thermo_pkg::LIMIT_RESET;
            low_q <= thermo_pkg::LIMIT_RESET;
            idx_q <= 1'b0;
            rd_word_q <= 16'h0000;
            rd_tgl_q <= 1'b0;
            cont_run_q <= 1'b0;
            active_q <= 1'b0;
            go_q <= 1'b0;
            nv_cnt_q <= '0;
        end else begin
            etgl_s1_q <= evt_tgl_q;
            etgl_s2_q <= etgl_s1_q;
            etgl_s3_q <= etgl_s2_q;
            st_q <= st_d;
            cmd_q <= cmd_d;
            hold_q <= hold_d;
            cfg_q <= cfg_d;
            high_q <= high_d;
            low_q <= low_d;
            idx_q <= idx_d;
            rd_word_q <= rd_word_d;
            rd_tgl_q <= rd_tgl_d;
            cont_run_q <= cont_run_d;
            active_q <= active_d;
            go_q <= go_d;
            nv_cnt_q <= nv_cnt_d;
        end
    end
    assign o_conv_go = go_q;
    assign o_conv_active = active_q;
    assign o_cont_mode = !cfg_q[thermo_pkg::CFG_ONESHOT_BIT];
    assign o_thermo_pol = cfg_q[thermo_pkg::CFG_POL_BIT];
    assign o_high_limit = high_q;
    assign o_low_limit = low_q;
    assign o_config = cfg_q;
    assign o_nv_busy = nv_cnt_q != '0;
    assign cmd_byte = evt_byte && st_q == thermo_pkg::ST_CMD;
    a_stop_ends_run: assert property (@(posedge i_clk) disable iff (!i_rstn)
        cmd_byte && evt_q.data == thermo_pkg::CMD_STOP_CONV |=> !cont_run_q && st_q == thermo_pkg::ST_HOLD)
        else $error("stop command left continuous run set");
    a_stop_no_abort: assert property (@(posedge i_clk) disable iff (!i_rstn)
        cmd_byte && evt_q.data == thermo_pkg::CMD_STOP_CONV && active_q && !i_conv_done
        |=> o_conv_active)
        else $error("stop aborted a running conversion");
    a_read_temp_word: assert property (@(posedge i_clk) disable iff (!i_rstn)
        cmd_byte && evt_q.data == thermo_pkg::CMD_READ_TEMP && !i_conv_done
        |=> rd_word_q == $past(i_temp) && rd_tgl_q != $past(rd_tgl_q))
        else $error("temperature word not loaded");
    a_count_word: assert property (@(posedge i_clk) disable iff (!i_rstn)
        cmd_byte && evt_q.data == thermo_pkg::CMD_READ_COUNT
        |=> rd_word_q[15:8] == $past(i_count_remain))
        else $error("remaining count not loaded");
    a_oneshot_idles: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_conv_done && active_q && !cont_run_q && !cmd_byte |=> !o_conv_active && !o_conv_go)
        else $error("one-shot conversion repeated");
    a_cont_repeats: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_conv_done && active_q && cont_run_q |=> o_conv_go ##1 !o_conv_go)
        else $error("continuous conversion not restarted");
    a_high_commit: assert property (@(posedge i_clk) disable iff (!i_rstn)
        commit && cmd_q == thermo_pkg::UPPER_THRESHOLD_CMD
        |=> o_high_limit == {$past(hold_q), $past(evt_q.data)})
        else $error("high limit not written");
    a_low_commit: assert property (@(posedge i_clk) disable iff (!i_rstn)
        commit && cmd_q == thermo_pkg::LOWER_THRESHOLD_CMD
        |=> o_low_limit == {$past(hold_q), $past(evt_q.data)} && $stable(o_high_limit))
        else $error("low limit not written");
    a_cfg_02_mode: assert property (@(posedge i_clk) disable iff (!i_rstn)
        commit && cmd_q == thermo_pkg::CMD_CONFIG && evt_q.data == 8'h02
        |=> o_thermo_pol && o_cont_mode && o_config == 8'h02)
        else $error("config 02h did not set mode");
    a_nv_window: assert property (@(posedge i_clk) disable iff (!i_rstn)
        commit |=> o_nv_busy && nv_cnt_q == NV_WRITE_CYC[thermo_pkg::NV_CNT_W-1:0])
        else $error("nonvolatile timer not loaded");
    a_unknown_inert: assert property (@(posedge i_clk) disable iff (!i_rstn)
        cmd_byte && evt_q.data == 8'h00 && !i_conv_done
        |=> $stable(o_config) && $stable(o_high_limit) && !o_conv_go && $stable(cont_run_q))
        else $error("unknown command changed state");
    a_restart_decode: assert property (@(posedge i_clk) disable iff (!i_rstn)
        evt_new && evt_q.kind == thermo_pkg::EVT_START |=> st_q == thermo_pkg::ST_ADDR)
        else $error("repeated start not honoured");
    a_addr_miss_nack: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
        i_lk_byte_vld && first_q && !lk_hit |-> !o_lk_ack ##1 !addressed_q)
        else $error("foreign address acknowledged");
    c_cont_start: cover property (@(posedge i_clk) disable iff (!i_rstn)
        cmd_byte && evt_q.data == thermo_pkg::CMD_START_CONV && o_cont_mode);
    c_cfg_write: cover property (@(posedge i_clk) disable iff (!i_rstn)
        commit && cmd_q == thermo_pkg::CMD_CONFIG);
    c_high_write: cover property (@(posedge i_clk) disable iff (!i_rstn)
        commit && cmd_q == thermo_pkg::UPPER_THRESHOLD_CMD);
    c_link_read: cover property (@(posedge i_link_clk) disable iff (!i_rstn)
        i_lk_rd_req && addressed_q && rd_mode_q && rd_idx_q);
endmodule // thermometer_command_decoder
`default_nettype wire

// file: thermo_pkg.sv
package thermo_pkg;
    // fixed device-type code in the upper nibble of the address byte
    localparam logic [3:0] DEV_TYPE = 4'h9;

    localparam logic [7:0] CMD_STOP_CONV = 8'h22;
    localparam logic [7:0] CMD_START_CONV = 8'hee;
    localparam logic [7:0] CMD_READ_TEMP = 8'haa;
    localparam logic [7:0] CMD_READ_COUNT = 8'ha8;
    localparam logic [7:0] CMD_READ_SLOPE = 8'ha9;
    localparam logic [7:0] UPPER_THRESHOLD_CMD = 8'ha1;
    localparam logic [7:0] LOWER_THRESHOLD_CMD = 8'ha2;
    localparam logic [7:0] CMD_CONFIG = 8'hac;

    localparam int CFG_ONESHOT_BIT = 0;
    localparam int CFG_POL_BIT = 1;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [15:0] LIMIT_RESET = 16'h0000;

    localparam int CLK_HZ = 125000000;
    localparam int NV_WRITE_MS = 10;
    // longest time: round down
    localparam int NV_WRITE_CYC = NV_WRITE_MS * (CLK_HZ / 1000);
    localparam int NV_CNT_W = 21;

    typedef enum logic [1:0] {
        EVT_START = 2'h0,
        EVT_STOP = 2'h1,
        EVT_BYTE = 2'h2
    } evt_kind_t;

    typedef struct packed {
        evt_kind_t kind;
        logic addr_byte;
        logic hit;
        logic [7:0] data;
    } link_evt_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ADDR = 5'h02,
        ST_CMD = 5'h04,
        ST_DATA = 5'h08,
        ST_HOLD = 5'h10
    } xact_state_t;
endpackage

// file: thermo_link_master.sv
`timescale 1ns/1ps
`default_nettype none
module thermo_link_master (
    input wire logic i_raw_clk,
    output logic o_link_clk,
    output logic o_start,
    output logic o_stop,
    output logic o_vld,
    output logic [7:0] o_byte,
    output logic o_rd_req
);
    logic run;
    // enable moves only while the raw clock is low, so no glitch
    assign o_link_clk = i_raw_clk & run;
    initial begin
        run = 1'b0;
        {o_start, o_stop, o_vld, o_rd_req} = 4'h0;
        o_byte = 8'h00;
    end
    // kind 0 start, 1 stop, 2 byte, 3 read request
    task automatic ev(input int k, input logic [7:0] b);
        @(negedge i_raw_clk);
        case (k)
            0: o_start = 1'b1;
            1: o_stop = 1'b1;
            2: begin
                o_vld = 1'b1;
                o_byte = b;
            end
            default: o_rd_req = 1'b1;
        endcase
        @(negedge i_raw_clk);
        {o_start, o_stop, o_vld, o_rd_req} = 4'h0;
        // released byte lines show no stale value
        o_byte = ~o_byte;
    endtask
    task automatic open();
        @(negedge i_raw_clk);
        run = 1'b1;
        repeat (3) @(negedge i_raw_clk);
        ev(0, 8'h00);
    endtask
    task automatic close();
        ev(1, 8'h00);
        // clock idles only after the core side has settled
        repeat (8) @(negedge i_raw_clk);
        run = 1'b0;
    endtask
endmodule // thermo_link_master
`default_nettype wire

// file: thermometer_command_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module thermometer_command_decoder_tb_top;
    localparam int NV = 200;
    logic i_clk, i_rstn, raw_clk, lk_clk, lk_start, lk_stop, lk_vld, rd_req, ack, done_p;
    logic go, active, cont, pol, nv_busy;
    logic [2:0] sel;
    logic [7:0] lk_byte, rd_byte, cnt, slope, cfg, hb;
    logic [15:0] temp, hi, lo, go_cnt, g;
    logic ack_q[$];
    logic [7:0] rd_q[$];
    int num_errors = 0;
    int checks_done = 0;
    integer seed;
    thermo_link_master m (.i_raw_clk(raw_clk), .o_link_clk(lk_clk), .o_start(lk_start),
        .o_stop(lk_stop), .o_vld(lk_vld), .o_byte(lk_byte), .o_rd_req(rd_req));
    thermometer_command_decoder #(.NV_WRITE_CYC(NV)) dut (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_link_clk(lk_clk), .i_addr_sel(sel), .i_lk_start(lk_start), .i_lk_stop(lk_stop),
        .i_lk_byte_vld(lk_vld), .i_lk_byte(lk_byte), .i_lk_rd_req(rd_req), .o_lk_ack(ack),
        .o_lk_rd_byte(rd_byte), .i_temp(temp), .i_count_remain(cnt), .i_count_per_c(slope),
        .i_conv_done(done_p), .o_conv_go(go), .o_conv_active(active), .o_cont_mode(cont),
        .o_thermo_pol(pol), .o_high_limit(hi), .o_low_limit(lo), .o_config(cfg),
        .o_nv_busy(nv_busy));
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    initial begin
        raw_clk = 1'b0;
        #3.3;
        forever #32 raw_clk = ~raw_clk;
    end
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn)
            go_cnt <= 16'h0000;
        else if (go === 1'b1)
            go_cnt <= go_cnt + 16'h0001;
    end
    always @(posedge lk_clk) begin
        if (lk_vld === 1'b1)
            check("ack", {15'h0000, ack_q.pop_front()}, {15'h0000, ack});
        if (rd_req === 1'b1) begin
            @(posedge lk_clk);
            #1;
            check("read byte", {8'h00, rd_q.pop_front()}, {8'h00, rd_byte});
        end
    end
    task automatic put(input logic [7:0] b, input logic a);
        ack_q.push_back(a);
        m.ev(2, b);
    endtask
    task automatic cmd(input logic [7:0] c);
        m.open();
        put({thermo_pkg::DEV_TYPE, sel, 1'b0}, 1'b1);
        put(c, 1'b1);
        m.close();
        repeat (20) @(negedge i_clk);
    endtask
    task automatic wr(input logic [7:0] c, input int n, input logic [15:0] d);
        m.open();
        put({thermo_pkg::DEV_TYPE, sel, 1'b0}, 1'b1);
        put(c, 1'b1);
        put(d[15:8], 1'b1);
        if (n > 1)
            put(d[7:0], 1'b1);
        m.close();
        check("nv busy", 16'h0001, {15'h0000, nv_busy});
        repeat (NV + 8) @(negedge i_clk);
        check("nv done", 16'h0000, {15'h0000, nv_busy});
        repeat (NV) @(negedge i_clk);
    endtask
    task automatic rd(input logic [7:0] c, input int n, input logic [15:0] w);
        m.open();
        put({thermo_pkg::DEV_TYPE, sel, 1'b0}, 1'b1);
        put(c, 1'b1);
        m.ev(0, 8'h00);
        put({thermo_pkg::DEV_TYPE, sel, 1'b1}, 1'b1);
        rd_q.push_back(w[15:8]);
        m.ev(3, 8'h00);
        if (n > 1) begin
            rd_q.push_back(w[7:0]);
            m.ev(3, 8'h00);
        end
        m.close();
    endtask
    task automatic done();
        @(negedge i_clk);
        done_p = 1'b1;
        @(negedge i_clk);
        done_p = 1'b0;
        repeat (6) @(negedge i_clk);
    endtask
    initial begin
        seed = 32'h8e83;
        i_rstn = 1'b0;
        done_p = 1'b0;
        sel = 3'($random(seed));
        temp = 16'($random(seed));
        cnt = 8'($random(seed));
        slope = 8'($random(seed));
        hb = 8'($random(seed));
        repeat (10) @(negedge i_clk);
        i_rstn = 1'b1;
        repeat (4) @(negedge i_clk);
        check("config", {8'h00, thermo_pkg::CFG_RESET}, {8'h00, cfg});
        check("high", thermo_pkg::LIMIT_RESET, hi);
        check("mode", 16'h0001, {15'h0000, cont});
        // foreign select, then foreign type code after a repeated start
        m.open();
        put({thermo_pkg::DEV_TYPE, ~sel, 1'b0}, 1'b0);
        put(thermo_pkg::CMD_CONFIG, 1'b0);
        m.ev(0, 8'h00);
        put({4'h8, sel, 1'b0}, 1'b0);
        put(8'h01, 1'b0);
        m.close();
        repeat (20) @(negedge i_clk);
        check("config", 16'h0000, {8'h00, cfg});
        wr(thermo_pkg::CMD_CONFIG, 1, 16'h0200);
        check("config", 16'h0002, {8'h00, cfg});
        check("polarity", 16'h0001, {15'h0000, pol});
        check("mode", 16'h0001, {15'h0000, cont});
        wr(thermo_pkg::UPPER_THRESHOLD_CMD, 2, {hb, 8'h00});
        check("high", {hb, 8'h00}, hi);
        wr(thermo_pkg::LOWER_THRESHOLD_CMD, 2, 16'h0a00);
        check("low", 16'h0a00, lo);
        g = go_cnt;
        cmd(8'h00);
        check("config", 16'h0002, {8'h00, cfg});
        check("high", {hb, 8'h00}, hi);
        check("go", g, go_cnt);
        rd(thermo_pkg::CMD_READ_TEMP, 2, temp);
        rd(thermo_pkg::CMD_READ_COUNT, 1, {cnt, 8'h00});
        rd(thermo_pkg::CMD_READ_SLOPE, 1, {slope, 8'h00});
        rd(thermo_pkg::CMD_CONFIG, 1, 16'h0200);
        rd(thermo_pkg::UPPER_THRESHOLD_CMD, 2, {hb, 8'h00});
        rd(thermo_pkg::LOWER_THRESHOLD_CMD, 2, 16'h0a00);
        cmd(thermo_pkg::CMD_START_CONV);
        check("go", g + 16'h0001, go_cnt);
        check("active", 16'h0001, {15'h0000, active});
        done();
        check("go", g + 16'h0002, go_cnt);
        cmd(thermo_pkg::CMD_STOP_CONV);
        check("active", 16'h0001, {15'h0000, active});
        done();
        check("go", g + 16'h0002, go_cnt);
        check("active", 16'h0000, {15'h0000, active});
        wr(thermo_pkg::CMD_CONFIG, 1, 16'h0100);
        check("mode", 16'h0000, {15'h0000, cont});
        repeat (2) begin
            g = go_cnt;
            cmd(thermo_pkg::CMD_START_CONV);
            check("go", g + 16'h0001, go_cnt);
            done();
            check("go", g + 16'h0001, go_cnt);
            check("active", 16'h0000, {15'h0000, active});
        end
        conclude();
    end
    initial begin
        #300000;
        num_errors++;
        conclude();
    end
endmodule // thermometer_command_decoder_tb_top
`default_nettype wire
